// >>> hdl/ircg_pkg.sv
package ircg_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] PADCFG_ADDR = 12'h004;
    localparam logic [11:0] STAT_ADDR = 12'h008;
    localparam logic [11:0] CNT_ADDR = 12'h00c;

    localparam int EN_BIT = 0;
    localparam int F57_BIT = 1;
    localparam int POL_BIT = 2;
    localparam int HINT_BIT = 7;
    localparam int PADSEL_BIT = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h87;
    localparam logic PADSEL_RESET = 1'b0;
    localparam logic [15:0] CNT_RESET = 16'h0000;

    // Status bit positions
    localparam int ST_RUN_BIT = 0;
    localparam int ST_CAR_BIT = 1;
    localparam int ST_PAD_BIT = 2;
    localparam int ST_INT_BIT = 3;
    localparam int ST_SEL_BIT = 4;

    // ----------------------------------------
    // Frequencies and half-period counts
    // ----------------------------------------
    localparam longint CAR57_HZ = 57000;
    localparam longint CAR38_HZ = 38000;
    localparam longint XTAL_HI_HZ = 3580000;
    localparam longint XTAL_LO_HZ = 455000;
    // Internal oscillator rate is a plain default
    localparam longint INT_OSC_HZ = 4000000;

    // Rounded to the nearest whole oscillator edge
    localparam logic [7:0] HALF_HI_57 = 8'((XTAL_HI_HZ + CAR57_HZ) / (2 * CAR57_HZ));
    localparam logic [7:0] HALF_HI_38 = 8'((XTAL_HI_HZ + CAR38_HZ) / (2 * CAR38_HZ));
    localparam logic [7:0] HALF_LO_57 = 8'((XTAL_LO_HZ + CAR57_HZ) / (2 * CAR57_HZ));
    localparam logic [7:0] HALF_LO_38 = 8'((XTAL_LO_HZ + CAR38_HZ) / (2 * CAR38_HZ));
    localparam logic [7:0] HALF_INT_57 = 8'((INT_OSC_HZ + CAR57_HZ) / (2 * CAR57_HZ));
    localparam logic [7:0] HALF_INT_38 = 8'((INT_OSC_HZ + CAR38_HZ) / (2 * CAR38_HZ));

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b11
    } ircg_st_e;

endpackage

// >>> hdl/ircg_car_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ircg_car_if;
    logic en;
    logic f57;
    logic hint;
    logic osc_int;
    logic osc_tick;
    logic pol;
    logic carrier;
    logic rise;

    modport ctl (output en, output f57, output hint, output osc_int, output osc_tick, output pol,
                 input carrier, input rise);
    modport gen (input en, input f57, input hint, input osc_int, input osc_tick,
                 output carrier, output rise);
    modport pad (input en, input pol, input carrier);
endinterface
`default_nettype wire

// >>> hdl/ircg_div.sv
`timescale 1ns/1ns
`default_nettype none
module ircg_div (
    input wire logic clk,
    input wire logic rst_n,
    ircg_car_if.gen car
);
    import ircg_pkg::*;

    ircg_st_e st_q;
    ircg_st_e st_d;
    logic [7:0] cnt_q;
    logic [7:0] half;
    logic wrap;

    // ----------------------------------------
    // Divider ratio
    // ----------------------------------------
    always_comb begin
        if (car.osc_int) begin
            half = car.f57 ? HALF_INT_57 : HALF_INT_38;
        end else if (car.hint) begin
            half = car.f57 ? HALF_HI_57 : HALF_HI_38;
        end else begin
            half = car.f57 ? HALF_LO_57 : HALF_LO_38;
        end
    end

    // Compare with >= so a ratio change mid-run cannot strand the counter
    assign wrap = car.osc_tick && (cnt_q >= half - 8'h01);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (!car.en || wrap) begin
            cnt_q <= 8'h00;
        end else if (car.osc_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Carrier phase
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (car.en) st_d = ST_LOW;
            end
            ST_LOW: begin
                if (!car.en) st_d = ST_IDLE;
                else if (wrap) st_d = ST_HIGH;
            end
            ST_HIGH: begin
                if (!car.en) st_d = ST_IDLE;
                else if (wrap) st_d = ST_LOW;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign car.carrier = (st_q == ST_HIGH);
    assign car.rise = (st_q == ST_LOW) && wrap && car.en;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_idle_quiet: assert property (!car.en |=> !car.carrier)
        else $error("carrier active while disabled");
    a_edge_on_tick: assert property ($changed(car.carrier) && $past(car.en) |-> $past(car.osc_tick))
        else $error("carrier edge without oscillator edge");
    // A ratio change may leave the count above the new limit until the next tick
    a_count_bound: assert property ($past(car.en) && $stable(half) && $past(cnt_q) < half
        |-> cnt_q < half)
        else $error("divider count beyond half period");
    a_hint_used: assert property (!car.osc_int && car.hint && car.f57 |-> half == HALF_HI_57)
        else $error("wrong ratio for fast crystal");
endmodule
`default_nettype wire

// >>> hdl/ircg_pad.sv
`timescale 1ns/1ns
`default_nettype none
module ircg_pad (
    input wire logic clk,
    input wire logic rst_n,
    ircg_car_if.pad car,
    input wire logic pad_sel,
    input wire logic out_data,
    input wire logic gpio_pa3_out,
    input wire logic gpio_pa3_oe,
    input wire logic gpio_pb1_out,
    input wire logic gpio_pb1_oe,
    output logic pa3_out,
    output logic pa3_oe,
    output logic pb1_out,
    output logic pb1_oe,
    output logic level_q
);
    import ircg_pkg::*;

    logic take_pa3;
    logic take_pb1;

    // Idle level is low so an attached LED stays dark
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= car.en && car.carrier && (out_data != car.pol);
        end
    end

    assign take_pa3 = car.en && !pad_sel;
    assign take_pb1 = car.en && pad_sel;

    // Port settings pass through untouched when released
    assign pa3_out = take_pa3 ? level_q : gpio_pa3_out;
    assign pa3_oe = take_pa3 ? 1'b1 : gpio_pa3_oe;
    assign pb1_out = take_pb1 ? level_q : gpio_pb1_out;
    assign pb1_oe = take_pb1 ? 1'b1 : gpio_pb1_oe;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pad_dir: assert property (car.en |-> (pad_sel ? pb1_oe : pa3_oe))
        else $error("infrared pad not driven");
    a_pad_release: assert property (!car.en |-> pa3_oe == gpio_pa3_oe && pb1_out == gpio_pb1_out)
        else $error("pad not returned to port");
    a_pad_route: assert property (car.en && !pad_sel |-> pa3_out == level_q && pb1_oe == gpio_pb1_oe)
        else $error("carrier on wrong pad");
    a_polarity_gap: assert property (out_data == car.pol |=> !level_q)
        else $error("carrier present in inactive data");
endmodule
`default_nettype wire

// >>> hdl/ircg_top.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module ircg_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic high_freq_osc_clock,
    input wire logic osc_internal_sel,
    input wire logic ir_out_data,
    input wire logic gpio_pa3_out,
    input wire logic gpio_pa3_oe,
    input wire logic gpio_pb1_out,
    input wire logic gpio_pb1_oe,
    output logic port_a_pin_3_out,
    output logic port_a_pin_3_oe,
    output logic port_b_pin_1_out,
    output logic port_b_pin_1_oe
);
    import ircg_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ----------------------------------------
    // Oscillator sampling
    // ----------------------------------------
    // Sampled, not used as a clock: keeps one domain at the cost of a
    // few ns of edge jitter on the carrier
    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= high_freq_osc_clock;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_q;
    logic padsel_q;
    logic [15:0] cnt_q;
    logic [31:0] rdata_q;
    logic setup;
    logic access;
    logic wr;
    logic mapped;
    logic ro_hit;
    logic pad_level;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign mapped = (paddr == CTRL_ADDR) || (paddr == PADCFG_ADDR)
                    || (paddr == STAT_ADDR) || (paddr == CNT_ADDR);
    assign ro_hit = (paddr == STAT_ADDR) || (paddr == CNT_ADDR);

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr && paddr == CTRL_ADDR) begin
            ctrl_q <= pwdata[7:0] & CTRL_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            padsel_q <= PADSEL_RESET;
        end else if (wr && paddr == PADCFG_ADDR) begin
            padsel_q <= pwdata[PADSEL_BIT];
        end
    end

    ircg_car_if car ();

    assign car.en = ctrl_q[EN_BIT];
    assign car.f57 = ctrl_q[F57_BIT];
    assign car.hint = ctrl_q[HINT_BIT];
    assign car.pol = ctrl_q[POL_BIT];
    assign car.osc_int = osc_internal_sel;
    assign car.osc_tick = osc_s2_q && !osc_s3_q;

    // Carrier periods since enable; wraps silently
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= CNT_RESET;
        end else if (!car.en) begin
            cnt_q <= CNT_RESET;
        end else if (car.rise) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            CTRL_ADDR: rd_mux[7:0] = ctrl_q;
            PADCFG_ADDR: rd_mux[PADSEL_BIT] = padsel_q;
            STAT_ADDR: begin
                rd_mux[ST_RUN_BIT] = car.en;
                rd_mux[ST_CAR_BIT] = car.carrier;
                rd_mux[ST_PAD_BIT] = pad_level;
                rd_mux[ST_INT_BIT] = osc_internal_sel;
                rd_mux[ST_SEL_BIT] = padsel_q;
            end
            CNT_ADDR: rd_mux[15:0] = cnt_q;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle so it leaves a flop
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && ro_hit));

    // ----------------------------------------
    // Carrier and pads
    // ----------------------------------------
    ircg_div u_div (
        .clk(clk),
        .rst_n(rst_n_q),
        .car(car.gen)
    );

    ircg_pad u_pad (
        .clk(clk),
        .rst_n(rst_n_q),
        .car(car.pad),
        .pad_sel(padsel_q),
        .out_data(ir_out_data),
        .gpio_pa3_out(gpio_pa3_out),
        .gpio_pa3_oe(gpio_pa3_oe),
        .gpio_pb1_out(gpio_pb1_out),
        .gpio_pb1_oe(gpio_pb1_oe),
        .pa3_out(port_a_pin_3_out),
        .pa3_oe(port_a_pin_3_oe),
        .pb1_out(port_b_pin_1_out),
        .pb1_oe(port_b_pin_1_oe),
        .level_q(pad_level)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    sequence s_ctrl_write;
        wr && paddr == CTRL_ADDR;
    endsequence

    a_ctrl_write: assert property (s_ctrl_write |=> ctrl_q == ($past(pwdata[7:0]) & CTRL_WMASK))
        else $error("control write not stored");
    a_bad_addr: assert property (access && !mapped |-> pslverr && pready)
        else $error("unmapped access not refused");
    // Only a start from idle is checked: a rewrite while running may land in a high phase
    a_start_run: assert property ((s_ctrl_write and (!car.en && pwdata[EN_BIT]))
        |=> car.en ##1 !car.carrier)
        else $error("carrier start sequence wrong");
endmodule
`default_nettype wire

// >>> tb/ircg_led_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Infrared LED driver on the chosen pad
// ----------------------------------------
// Counts light pulses and measures each period in oscillator rising edges.
// Only the driven pad lights the LED; an undriven pad reads as dark.
module ircg_led_model (
    input wire logic clk,
    input wire logic osc,
    input wire logic drive_out,
    input wire logic drive_oe,
    output int rises,
    output int period
);
    logic osc_q = 1'b0;
    logic light_q = 1'b0;
    int ocnt = 0;
    int since = 0;
    wire logic light = drive_out & drive_oe;
    initial rises = 0;
    initial period = 0;
    always @(posedge clk) begin
        osc_q <= osc;
        light_q <= light;
        if (osc && !osc_q) begin
            ocnt <= ocnt + 1;
        end
        if (light && !light_q) begin
            rises <= rises + 1;
            period <= ocnt - since;
            since <= ocnt;
        end
    end
endmodule
`default_nettype wire

// >>> tb/ircg_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ircg_top_tb_top;
    import ircg_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h3ac4;
    logic pready, pslverr, er, osc_int = 1'b0, odata = 1'b0, sel, pol;
    logic [2:0] oc = 3'h0;
    logic [3:0] gp = 4'h0;
    wire logic [3:0] pv;
    int mismatches = 0, n_checks = 0, rises, period, r0, hv;
    // ----------------------------------------
    // Clock, oscillator, design and LED
    // ----------------------------------------
    initial forever #2 clk = ~clk;
    // Oscillator is far slower than clk so each of its edges is seen
    always @(posedge clk) oc <= oc + 3'h1;
    ircg_top DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .high_freq_osc_clock(oc[2]), .osc_internal_sel(osc_int), .ir_out_data(odata),
        .gpio_pa3_out(gp[0]), .gpio_pa3_oe(gp[1]), .gpio_pb1_out(gp[2]), .gpio_pb1_oe(gp[3]),
        .port_a_pin_3_out(pv[0]), .port_a_pin_3_oe(pv[1]),
        .port_b_pin_1_out(pv[2]), .port_b_pin_1_oe(pv[3]));
    ircg_led_model LED (.clk(clk), .osc(oc[2]), .drive_out(sel ? pv[2] : pv[0]),
        .drive_oe(sel ? pv[3] : pv[1]), .rises(rises), .period(period));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int hexp(bit i, bit h, bit f);
        if (i) return f ? HALF_INT_57 : HALF_INT_38;
        if (h) return f ? HALF_HI_57 : HALF_HI_38;
        return f ? HALF_LO_57 : HALF_LO_38;
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic close_out();
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #260000;
        mismatches++;
        close_out();
    end
    initial begin
        sel = 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, {24'h0, CTRL_RESET});
        // Reserved bits must not stick, enable stays off here
        apb(1'b1, CTRL_ADDR, 32'hfe);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk(rd, 32'h86);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, STAT_ADDR, 32'h1);
        chk(er, 1'b1);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            sel = rnd[0];
            pol = rnd[1];
            gp <= rnd[5:2];
            osc_int <= k[2];
            odata <= !pol;
            hv = hexp(k[2], k[1], k[0]);
            apb(1'b1, PADCFG_ADDR, {31'h0, sel});
            apb(1'b1, CTRL_ADDR, {24'h0, k[1], 4'h0, pol, k[0], 1'b1});
            @(posedge clk);
            chk(sel ? {pv[3], pv[1:0]} : pv[3:1], sel ? {1'b1, gp[1:0]} : {gp[3:2], 1'b1});
            r0 = rises;
            for (int i = 0; i < 6000 && rises < r0 + 3; i++) @(posedge clk);
            chk(period, 2 * hv);
            // Three carrier periods since enable; the next one is far off
            apb(1'b0, CNT_ADDR, 32'h0);
            chk(rd, 32'h3);
            odata <= pol;
            repeat (20) @(posedge clk);
            r0 = rises;
            repeat (16 * hv + 16) @(posedge clk);
            chk(rises, r0);
            chk(sel ? pv[2] : pv[0], 1'b0);
            // Raw carrier bit runs free, so it is masked out
            apb(1'b0, STAT_ADDR, 32'h0);
            chk(rd & 32'hffff_fffd, {27'h0, sel, k[2], 3'h1});
            apb(1'b1, CTRL_ADDR, 32'h0);
            @(posedge clk);
            chk(pv, gp);
        end
        close_out();
    end
endmodule
`default_nettype wire
